// *** src/eke_defines.svh ***
// Offsets, field positions, reset values and opcodes of the nonvolatile
// key and command engine. Assumes inclusion by bare name from src/.
`ifndef EKE_DEFINES_SVH
`define EKE_DEFINES_SVH

// Register indexes; byte address is four times the index
`define EKE_IDX_CMD   7'h00
`define EKE_IDX_HCTL  7'h01
`define EKE_IDX_QCTL  7'h02
`define EKE_IDX_QTHR  7'h03
`define EKE_IDX_QLEN  7'h04
`define EKE_IDX_DATA  7'h05
`define EKE_IDX_EVTA  7'h06
`define EKE_IDX_EVTB  7'h07
`define EKE_IDX_MSKA  7'h08
`define EKE_IDX_MSKB  7'h09
`define EKE_IDX_ERR   7'h0A
`define EKE_IDX_STAT  7'h0B
`define EKE_IDX_CFG0  7'h0C
// Opcodes
`define EKE_OP_IDLE   8'h00
`define EKE_OP_PAGE   8'h09
`define EKE_OP_FETCH  8'h0A
`define EKE_OP_COPY   8'h0C
`define EKE_OP_PRESET 8'h0D
`define EKE_OP_KLOAD  8'h0E
`define EKE_OP_KSAVE  8'h0F
`define EKE_OP_RAND   8'h1C
`define EKE_OP_RELOAD 8'h1F
// Limits and nonvolatile layout
`define EKE_PAGE_LEN  9'h040
`define EKE_PAGE_MAX  8'h7F
`define EKE_ADRH_MAX  8'h1F
`define EKE_PROTO_MAX 8'h03
`define EKE_KEY_LEN   3'h5
`define EKE_KEY_BYTES 9'h006
`define EKE_DEF_BASE  13'h0080
`define EKE_RXP_BASE  13'h0A00
`define EKE_TXP_BASE  13'h0A10
`define EKE_KEY_BASE  13'h0C00
`define EKE_RX_CFG    7'h35
`define EKE_TX_CFG    7'h33
`define EKE_CFG_LAST  7'h7F
// Queue capacity, field bits, reset values
`define EKE_QCAP      9'h100
`define EKE_QC_FLUSH  4
`define EKE_ERR_PARAM 0
`define EKE_ERR_RANGE 1
`define EKE_ERR_QOVF  2
`define EKE_ERR_QUNF  3
`define EKE_EV_DONE   0
`define EKE_EV_HI     1
`define EKE_EV_LO     2
`define EKE_EV_ERR    3
`define EKE_THR_RST   8'h08
`define EKE_LFSR_SEED 16'hACE1
`endif

// *** src/eke_pkg.sv ***
// Types of the nonvolatile key and command engine.
// Assumes eke_defines.svh is compiled alongside.
package eke_pkg;
	// Engine states
	typedef enum logic [3:0] {
		S_IDLE = 4'h0, S_PAGE = 4'h1, S_FETCH = 4'h2, S_COPY = 4'h3,
		S_PRESET = 4'h4, S_KLOAD = 4'h5, S_KSAVE = 4'h6, S_RAND = 4'h7,
		S_RELOAD = 4'h8, S_PARAM = 4'h9
	} eke_fsm_t;
	// Bus data phase held over from the address phase
	typedef struct packed {
		logic       act;
		logic       wr;
		logic [6:0] idx;
	} eke_dph_t;
	// Whole module state
	typedef struct packed {
		eke_fsm_t        fsm;
		logic [7:0]      cmd, hctl, qthr, msk_a, msk_b, evt, err, op;
		logic [2:0]      pcnt;
		logic [3:0][7:0] par;
		logic [12:0]     adr;
		logic [8:0]      len;
		logic [6:0]      ridx;
		logic [7:0]      slot;
		logic [2:0]      kcnt;
		logic [47:0]     key;
		logic [15:0]     lfsr;
		logic [7:0]      rp, wp;
		logic [8:0]      qcnt;
		eke_dph_t        dph;
		logic [7:0]      rdat;
		logic            rdy, rsp;
	} eke_st_t;
endpackage

// *** src/eke_engine.sv ***
// Nonvolatile key and command engine behind an AHB-Lite slave.
// Assumes one clock hclk, single whole-word transfers, zero wait states.
`timescale 1ns/1ps
`include "eke_defines.svh"
`default_nettype none
module eke_engine #(
	parameter logic [7:0] KEY_SLOTS = 8'h80 // Secret slots in storage area
) (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Secret buffer towards the crypto unit
	output logic      [47:0] secret_key
);
	////////////////////////////////////////////////////////////////////////
	eke_pkg::eke_st_t s, n;       // State and its next value
	logic [7:0]  nvm [0:8191];    // Nonvolatile array, byte wide
	logic [7:0]  que [0:255];     // Data queue storage
	logic [7:0]  cfg [0:127];     // Configuration register set
	logic        nvm_we;          // Nonvolatile write strobe
	logic [12:0] nvm_wa, nvm_ra;  // Write and read addresses
	logic [7:0]  nvm_wd, nvm_rd;  // Write and read data
	logic        cfg_we;          // Config write strobe
	logic [6:0]  cfg_wa;          // Config write index
	logic [7:0]  cfg_wd;          // Config write data
	logic        push, pop;       // Queue strobes, at most one each
	logic [7:0]  push_d;          // Queue write data
	logic        e_push, e_pop;   // Engine share of the strobes
	logic [7:0]  q_head;          // Oldest queued byte
	logic        q_empty, q_full; // Queue state
	logic        ap_ok;           // Address phase taken
	logic        st_w;            // Command write in data phase
	logic        lack;            // Too few parameters on start
	logic [7:0]  ev_set;          // Event sets this cycle
	logic [7:0]  wd;              // Low data byte of a write

	assign q_head  = que[s.rp];
	assign q_empty = (s.qcnt == 9'h000);
	assign q_full  = (s.qcnt == `EKE_QCAP);
	assign nvm_rd  = nvm[nvm_ra];
	// Read address from state alone, so the read data never loops back into it
	assign nvm_ra  = (s.fsm == eke_pkg::S_RELOAD) ? `EKE_DEF_BASE + {6'h00, s.ridx}
	               : (s.fsm != eke_pkg::S_PRESET) ? s.adr
	               : (s.kcnt == 3'h0) ? `EKE_RXP_BASE + {5'h00, s.par[0]}
	               : `EKE_TXP_BASE + {5'h00, s.par[1]};
	assign wd      = hwdata[7:0];
	assign ap_ok   = hsel & htrans[1] & hready & (haddr[31:9] == 23'h0);

	// Outputs come straight from state flops
	assign hrdata     = {24'h0, s.rdat};
	assign hreadyout  = s.rdy;
	assign hresp      = s.rsp;
	assign secret_key = s.key;

	////////////////////////////////////////////////////////////////////////
	// Bytes that must be queued before a command may start
	function automatic logic [8:0] need(input logic [7:0] op);
		case (op)
			`EKE_OP_PAGE:   need = 9'h002; // Page plus one byte
			`EKE_OP_FETCH:  need = 9'h003;
			`EKE_OP_COPY:   need = 9'h004;
			`EKE_OP_PRESET: need = 9'h002;
			`EKE_OP_KLOAD:  need = 9'h001;
			`EKE_OP_KSAVE:  need = 9'h007; // Slot plus one secret
			default:        need = 9'h000;
		endcase
	endfunction

	// Parameter bytes popped before dispatch
	function automatic logic [2:0] npar(input logic [7:0] op);
		case (op)
			`EKE_OP_PAGE, `EKE_OP_KLOAD, `EKE_OP_KSAVE: npar = 3'h1;
			`EKE_OP_FETCH:                            npar = 3'h3;
			`EKE_OP_COPY:                             npar = 3'h4;
			`EKE_OP_PRESET:                           npar = 3'h2;
			default:                                  npar = 3'h0;
		endcase
	endfunction

	// Host read value; reserved bits read zero
	function automatic logic [7:0] rd_val(input logic [6:0] i);
		case (i)
			`EKE_IDX_CMD:  rd_val = s.cmd;
			`EKE_IDX_HCTL: rd_val = s.hctl;
			`EKE_IDX_QCTL: rd_val = {7'h0, s.qcnt[8]}; // Flush bit reads 0
			`EKE_IDX_QTHR: rd_val = s.qthr;
			`EKE_IDX_QLEN: rd_val = s.qcnt[7:0];
			`EKE_IDX_DATA: rd_val = q_head;
			`EKE_IDX_EVTA: rd_val = s.evt;
			`EKE_IDX_EVTB: rd_val = 8'h00;
			`EKE_IDX_MSKA: rd_val = s.msk_a;
			`EKE_IDX_MSKB: rd_val = s.msk_b;
			`EKE_IDX_ERR:  rd_val = s.err;
			`EKE_IDX_STAT: rd_val = {3'h0, s.fsm != eke_pkg::S_IDLE, s.fsm};
			default:       rd_val = cfg[i];
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Next state: engine first, then the bus, then event sets
	always_comb begin
		n      = s;
		nvm_we = 1'b0;
		nvm_wa = s.adr;
		nvm_wd = q_head;
		cfg_we = 1'b0;
		cfg_wa = s.ridx;
		cfg_wd = nvm_rd;
		e_push = 1'b0;
		e_pop  = 1'b0;
		push   = 1'b0;
		pop    = 1'b0;
		push_d = nvm_rd;
		ev_set = 8'h00;
		st_w   = 1'b0;
		lack   = 1'b0;
		n.lfsr = {s.lfsr[14:0], s.lfsr[15] ^ s.lfsr[13] ^ s.lfsr[12] ^ s.lfsr[10]};
		case (s.fsm)
			// Parameters leave the queue in order
			eke_pkg::S_PARAM: begin
				e_pop           = 1'b1;
				n.par[s.pcnt[1:0]] = q_head;
				n.pcnt          = s.pcnt + 3'h1;
				if (n.pcnt == npar(s.op)) begin
					n.kcnt = 3'h0;
					case (s.op)
						`EKE_OP_PAGE: begin
							n.adr = {n.par[0][6:0], 6'h00};
							n.len = 9'h000;
							n.fsm = eke_pkg::S_PAGE;
							if (n.par[0] > `EKE_PAGE_MAX)
								n.fsm = eke_pkg::S_IDLE;
						end
						`EKE_OP_FETCH, `EKE_OP_COPY: begin
							n.adr  = {n.par[0][4:0], n.par[1]};
							n.ridx = n.par[2][6:0];
							if (s.op == `EKE_OP_FETCH) begin
								n.len = (n.par[2] == 8'h00) ? 9'h100 : {1'b0, n.par[2]};
								n.fsm = eke_pkg::S_FETCH;
							end else begin
								n.len = {1'b0, n.par[3]};
								n.fsm = eke_pkg::S_COPY;
							end
							if (n.par[0] > `EKE_ADRH_MAX)
								n.fsm = eke_pkg::S_IDLE;
						end
						`EKE_OP_PRESET: begin
							n.fsm = eke_pkg::S_PRESET;
							if (n.par[0] > `EKE_PROTO_MAX || n.par[1] > `EKE_PROTO_MAX)
								n.fsm = eke_pkg::S_IDLE;
						end
						default: begin // Secret load or save
							n.slot = n.par[0];
							n.adr  = `EKE_KEY_BASE + {5'h00, n.par[0]} * 13'h0006;
							n.fsm  = (s.op == `EKE_OP_KLOAD) ? eke_pkg::S_KLOAD
							                                 : eke_pkg::S_KSAVE;
							if (n.par[0] >= KEY_SLOTS)
								n.fsm = eke_pkg::S_IDLE;
						end
					endcase
					// Bad range: stop, idle, flag, nothing written
					if (n.fsm == eke_pkg::S_IDLE) begin
						n.cmd                = `EKE_OP_IDLE;
						n.err[`EKE_ERR_RANGE] = 1'b1;
						ev_set[`EKE_EV_ERR]   = 1'b1;
						ev_set[`EKE_EV_DONE]  = 1'b1;
					end
				end
			end
			// Page bytes; stops at page end or empty queue
			eke_pkg::S_PAGE: begin
				if (q_empty || s.len == `EKE_PAGE_LEN) begin
					n.fsm = eke_pkg::S_IDLE;
				end else begin
					e_pop  = 1'b1;
					nvm_we = 1'b1;
					nvm_wa = s.adr + {4'h0, s.len};
					n.len  = s.len + 9'h001;
				end
			end
			// Fetch into the queue, waits while it is full
			eke_pkg::S_FETCH: begin
				if (s.len == 9'h000) begin
					n.fsm = eke_pkg::S_IDLE;
				end else if (!q_full) begin
					e_push = 1'b1;
					n.adr  = s.adr + 13'h0001; // 13 bits wrap to 0000h
					n.len  = s.len - 9'h001;
				end
			end
			// Copy into consecutive config registers
			eke_pkg::S_COPY: begin
				if (s.len == 9'h000) begin
					n.fsm = eke_pkg::S_IDLE;
				end else begin
					cfg_we = 1'b1;
					n.adr  = s.adr + 13'h0001;
					n.ridx = s.ridx + 7'h01;
					n.len  = s.len - 9'h001;
				end
			end
			// Stored preset entries hold the rate and coding
			eke_pkg::S_PRESET: begin
				cfg_we = 1'b1;
				if (s.kcnt == 3'h0) begin
					cfg_wa = `EKE_RX_CFG;
					n.kcnt = 3'h1;
				end else begin
					cfg_wa = `EKE_TX_CFG;
					n.fsm  = eke_pkg::S_IDLE;
				end
			end
			// Six stored bytes into the secret buffer
			eke_pkg::S_KLOAD: begin
				n.key  = {s.key[39:0], nvm_rd};
				n.adr  = s.adr + 13'h0001;
				n.kcnt = s.kcnt + 3'h1;
				if (s.kcnt == `EKE_KEY_LEN)
					n.fsm = eke_pkg::S_IDLE;
			end
			// Whole secrets only; a partial one stays queued
			eke_pkg::S_KSAVE: begin
				if (s.kcnt == 3'h0 && (s.qcnt < `EKE_KEY_BYTES || s.slot >= KEY_SLOTS)) begin
					n.fsm = eke_pkg::S_IDLE;
				end else begin
					e_pop  = 1'b1;
					nvm_we = 1'b1;
					n.adr  = s.adr + 13'h0001;
					n.kcnt = (s.kcnt == `EKE_KEY_LEN) ? 3'h0 : s.kcnt + 3'h1;
					if (s.kcnt == `EKE_KEY_LEN)
						n.slot = s.slot + 8'h01;
				end
			end
			// Random bytes until the queue is full
			eke_pkg::S_RAND: begin
				push_d = s.lfsr[7:0];
				if (q_full)
					n.fsm = eke_pkg::S_IDLE;
				else
					e_push = 1'b1;
			end
			// Defaults reload into the whole register set
			eke_pkg::S_RELOAD: begin
				cfg_we = 1'b1;
				case (s.ridx)
					`EKE_IDX_HCTL: n.hctl  = nvm_rd;
					`EKE_IDX_QTHR: n.qthr  = nvm_rd;
					`EKE_IDX_MSKA: n.msk_a = nvm_rd;
					`EKE_IDX_MSKB: n.msk_b = nvm_rd;
					default: ;
				endcase
				n.ridx = s.ridx + 7'h01;
				if (s.ridx == `EKE_CFG_LAST)
					n.fsm = eke_pkg::S_IDLE;
			end
			default: ;
		endcase
		// Normal completion hands the command register back
		if (s.fsm != eke_pkg::S_IDLE && s.fsm != eke_pkg::S_PARAM
		    && n.fsm == eke_pkg::S_IDLE) begin
			n.cmd                = `EKE_OP_IDLE;
			ev_set[`EKE_EV_DONE] = 1'b1;
		end

		// Bus data phase: register writes by access class
		if (s.dph.act && s.dph.wr) begin
			case (s.dph.idx)
				`EKE_IDX_CMD:  st_w = 1'b1;
				`EKE_IDX_HCTL: n.hctl = wd;
				`EKE_IDX_QTHR: n.qthr = wd;
				`EKE_IDX_MSKA: n.msk_a = wd;
				`EKE_IDX_MSKB: n.msk_b = wd;
				`EKE_IDX_EVTA: n.evt = s.evt & ~wd; // Write one to clear
				`EKE_IDX_DATA: begin
					if (q_full || e_push)
						n.err[`EKE_ERR_QOVF] = 1'b1;
					else
						push = 1'b1;
				end
				`EKE_IDX_QCTL, `EKE_IDX_QLEN, `EKE_IDX_EVTB, `EKE_IDX_ERR,
				`EKE_IDX_STAT: ;
				default: begin
					if (!cfg_we) begin
						cfg_we = 1'b1;
						cfg_wa = s.dph.idx;
						cfg_wd = wd;
					end
				end
			endcase
		end
		// Command write: idle stops, anything else restarts
		if (st_w) begin
			n.cmd = wd;
			n.op  = wd;
			n.fsm = eke_pkg::S_IDLE;
			if (wd != `EKE_OP_IDLE) begin
				n.err  = 8'h00;
				n.pcnt = 3'h0;
				n.ridx = 7'h00;
				lack   = (s.qcnt < need(wd));
				if (lack) begin
					n.cmd                 = `EKE_OP_IDLE;
					n.err[`EKE_ERR_PARAM] = 1'b1;
					ev_set[`EKE_EV_ERR]   = 1'b1;
					ev_set[`EKE_EV_DONE]  = 1'b1;
				end else if (npar(wd) != 3'h0) begin
					n.fsm = eke_pkg::S_PARAM;
				end else if (wd == `EKE_OP_RAND) begin
					n.fsm = eke_pkg::S_RAND;
				end else if (wd == `EKE_OP_RELOAD) begin
					n.fsm = eke_pkg::S_RELOAD;
				end else begin
					n.cmd                = `EKE_OP_IDLE;
					ev_set[`EKE_EV_DONE] = 1'b1;
				end
			end
		end
		// Bus address phase after the command write, so a same-cycle error set wins
		n.rdy     = 1'b1;
		n.rsp     = 1'b0;
		n.dph.act = ap_ok;
		n.dph.wr  = hwrite;
		n.dph.idx = haddr[8:2];
		if (hsel && htrans[1] && hready && !hwrite && !ap_ok)
			n.rdat = 8'h00; // Unmapped reads return zero
		if (ap_ok && !hwrite) begin
			n.rdat = rd_val(haddr[8:2]);
			if (haddr[8:2] == `EKE_IDX_DATA) begin
				if (q_empty || e_pop)
					n.err[`EKE_ERR_QUNF] = 1'b1;
				else
					pop = 1'b1;
			end
		end
		// Queue bookkeeping; engine strobes dropped by a restart into another state
		if (s.fsm == n.fsm || !st_w) begin
			push = push | e_push;
			pop  = pop | e_pop;
		end
		if (st_w)
			nvm_we = 1'b0;
		if (push && !e_push)
			push_d = wd;
		n.wp   = push ? s.wp + 8'h01 : s.wp;
		n.rp   = pop ? s.rp + 8'h01 : s.rp;
		n.qcnt = s.qcnt + {8'h00, push} - {8'h00, pop};
		if (s.dph.act && s.dph.wr && s.dph.idx == `EKE_IDX_QCTL && wd[`EKE_QC_FLUSH]) begin
			n.wp   = 8'h00;
			n.rp   = 8'h00;
			n.qcnt = 9'h000;
		end
		// Level events; a set wins over a same-cycle clear
		ev_set[`EKE_EV_HI] = (s.qcnt >= {1'b0, s.qthr});
		ev_set[`EKE_EV_LO] = (s.qcnt <= {1'b0, s.qthr});
		n.evt = n.evt | ev_set;
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s      <= '0;
			s.rdy  <= 1'b1;
			s.qthr <= `EKE_THR_RST;
			s.lfsr <= `EKE_LFSR_SEED;
		end else begin
			s <= n;
		end
	end

	// Memories carry no reset; contents persist
	always_ff @(posedge hclk) begin
		if (nvm_we)
			nvm[nvm_wa] <= nvm_wd;
		if (cfg_we)
			cfg[cfg_wa] <= cfg_wd;
		if (push)
			que[s.wp] <= push_d;
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	a_idle_stop: assert property (@(posedge hclk) disable iff (!hresetn)
		st_w && wd == `EKE_OP_IDLE |=> s.fsm == eke_pkg::S_IDLE && s.cmd == 8'h00)
		else $error("idle write did not stop the engine");
	a_lack_abort: assert property (@(posedge hclk) disable iff (!hresetn)
		st_w && lack |=> s.err[`EKE_ERR_PARAM] && s.cmd == 8'h00 && !nvm_we)
		else $error("missing parameters not aborted");
	a_nvm_source: assert property (@(posedge hclk) disable iff (!hresetn)
		nvm_we |-> s.fsm == eke_pkg::S_PAGE || s.fsm == eke_pkg::S_KSAVE)
		else $error("memory written outside page or secret save");
	a_page_bound: assert property (@(posedge hclk) disable iff (!hresetn)
		nvm_we && s.fsm == eke_pkg::S_PAGE |-> s.len < 9'h040 && nvm_wa[12:6] == s.adr[12:6])
		else $error("page write crossed its page");
	a_fetch_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
		s.fsm == eke_pkg::S_FETCH && e_push && !st_w && s.adr == 13'h1FFF |=> s.adr == 13'h0000)
		else $error("fetch did not wrap to zero");
	a_key_whole: assert property (@(posedge hclk) disable iff (!hresetn)
		s.fsm == eke_pkg::S_KSAVE && s.kcnt == 3'h0 && s.qcnt < 9'h006 && !st_w
		|-> (!e_pop && !nvm_we) ##1 s.fsm == eke_pkg::S_IDLE)
		else $error("partial secret taken from queue");
	a_rand_full: assert property (@(posedge hclk) disable iff (!hresetn)
		s.fsm == eke_pkg::S_RAND && !q_full && !st_w |=> s.qcnt != 9'h000)
		else $error("random fill stalled");
	a_wo_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		ap_ok && !hwrite && haddr[8:2] == `EKE_IDX_QCTL |=> hrdata[7:1] == 7'h00)
		else $error("write-only flush bit read back");
endmodule
`default_nettype wire

// *** test/eke_host.sv ***
// Host controller model: AHB-Lite master issuing single word transfers.
// Assumes hready is the engine's hreadyout and hsel is held high.
`timescale 1ns/1ps
`default_nettype none
module eke_host (
	// Clock
	input  wire logic        hclk,
	// Bus towards the engine
	output logic      [1:0]  htrans,
	output logic      [31:0] haddr,
	output logic             hwrite,
	output logic      [31:0] hwdata,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata
);
	////////////////////////////////////////////////////////////////////
	// Quiet bus from time zero
	initial begin
		htrans = 2'h0;
		haddr  = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
	end

	// One transfer; the only byte used travels in bits 7:0
	task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge hclk);
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= w;
		// Address phase held until taken
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		// Read data is taken at the closing edge of the data phase
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata[7:0];
		// Stale write data is inverted so nothing leans on it
		hwdata <= ~hwdata;
	endtask
endmodule
`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench of the key and command engine.
// Assumes the host model drives the bus and hready loops back.
`timescale 1ns/1ps
`default_nettype none
`include "eke_defines.svh"
module tb;
	// Bus and engine outputs
	logic        hclk;
	logic        hresetn;
	logic [1:0]  htrans;
	logic [31:0] haddr;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hready;
	logic        hresp;
	logic [47:0] secret_key;
	// Score, watchdog, last read byte
	int          n_mismatch;
	int          checked;
	int          cyc;
	logic [7:0]  v;
	// Start page of sector two, read back by the copy test at 0100h
	localparam logic [7:0] SEC2_PAGE = 8'h04;

	eke_engine eke_engine_inst (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
		.hresp(hresp), .secret_key(secret_key));
	eke_host eke_host_inst (.hclk(hclk), .htrans(htrans), .haddr(haddr),
		.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));

	////////////////////////////////////////////////////////////////////
	// Compare and report
	task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] e);
		checked++;
		if (seen !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, seen);
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Register access by index
	task automatic wr(input logic [6:0] i, input logic [7:0] d);
		logic [7:0] q;
		eke_host_inst.xfer(1'b1, {23'h0, i, 2'h0}, d, q);
	endtask
	task automatic rdx(input string nm, input logic [6:0] i, input logic [7:0] e);
		eke_host_inst.xfer(1'b0, {23'h0, i, 2'h0}, 8'h00, v);
		chk(nm, {40'h0, v}, {40'h0, e});
	endtask
	// Queue helpers; parameters must be queued before the opcode
	task automatic q1(input logic [7:0] d);
		wr(`EKE_IDX_DATA, d);
	endtask
	task automatic pushn(input logic [7:0] base, input int n);
		for (int k = 0; k < n; k++) begin
			q1(base + 8'(k));
		end
	endtask
	task automatic flush();
		wr(`EKE_IDX_QCTL, 8'h10);
	endtask
	// Start an opcode, poll the command register for idle
	task automatic run(input logic [7:0] op);
		wr(`EKE_IDX_CMD, op);
		// Only the watchdog ends a command that never returns to idle
		do begin
			eke_host_inst.xfer(1'b0, 32'h0, 8'h00, v);
		end while (v !== 8'h00);
	endtask
	task automatic wpage(input logic [7:0] pg, input logic [7:0] base, input int n);
		flush();
		q1(pg);
		pushn(base, n);
		run(`EKE_OP_PAGE);
	endtask
	task automatic fetch(input logic [15:0] a, input logic [7:0] n);
		flush();
		q1(a[15:8]);
		q1(a[7:0]);
		q1(n);
		run(`EKE_OP_FETCH);
	endtask

	////////////////////////////////////////////////////////////////////
	// Reset values, access classes, unmapped read
	task automatic t_regs();
		rdx("command", `EKE_IDX_CMD, 8'h00);
		rdx("threshold", `EKE_IDX_QTHR, `EKE_THR_RST);
		rdx("error", `EKE_IDX_ERR, 8'h00);
		chk("hresp", {47'h0, hresp}, 48'h0);
		wr(`EKE_IDX_QTHR, 8'h5A);
		rdx("threshold rw", `EKE_IDX_QTHR, 8'h5A);
		// Straight after a nonzero read, so a stale answer shows
		eke_host_inst.xfer(1'b0, 32'h0000_0200, 8'h00, v);
		chk("unmapped", {40'h0, v}, 48'h0);
		wr(`EKE_IDX_QLEN, 8'h33);
		rdx("fill ro", `EKE_IDX_QLEN, 8'h00);
		rdx("events b", `EKE_IDX_EVTB, 8'h00);
		// Host keeps untouched bits by read-modify-write
		rdx("host ctl", `EKE_IDX_HCTL, 8'h00);
		wr(`EKE_IDX_HCTL, v | 8'h02);
		rdx("host ctl rmw", `EKE_IDX_HCTL, 8'h02);
	endtask
	// Page write with overflow, then aborts
	task automatic t_page();
		wpage(8'h01, 8'h40, 70);
		rdx("command done", `EKE_IDX_CMD, 8'h00);
		rdx("page excess", `EKE_IDX_QLEN, 8'h06);
		rdx("excess head", `EKE_IDX_DATA, 8'h80);
		fetch(16'h0040, 8'h02);
		rdx("page first", `EKE_IDX_DATA, 8'h40);
		rdx("page second", `EKE_IDX_DATA, 8'h41);
		flush();
		q1(8'h80);
		q1(8'h00);
		run(`EKE_OP_PAGE);
		rdx("page range", `EKE_IDX_ERR, 8'h02);
		rdx("range kept", `EKE_IDX_QLEN, 8'h01);
		flush();
		q1(8'h01);
		// Clear events; only the low level bit comes straight back
		wr(`EKE_IDX_EVTA, 8'hFF);
		run(`EKE_OP_PAGE);
		rdx("page params", `EKE_IDX_ERR, 8'h01);
		rdx("abort events", `EKE_IDX_EVTA, 8'h0D);
		fetch(16'h0040, 8'h01);
		rdx("page untouched", `EKE_IDX_DATA, 8'h40);
	endtask
	// Fetch across the top of the array, copy into registers
	task automatic t_fetch_copy();
		wpage(8'h7F, 8'h80, 64);
		wpage(8'h00, 8'h10, 2);
		fetch(16'h1FFE, 8'h04);
		for (int k = 0; k < 4; k++) begin
			rdx("wrap", `EKE_IDX_DATA, (k < 2) ? 8'hBE + 8'(k) : 8'h0E + 8'(k));
		end
		fetch(16'h2000, 8'h01);
		rdx("fetch range", `EKE_IDX_ERR, 8'h02);
		wpage(SEC2_PAGE, 8'hC0, 3);
		flush();
		pushn(8'h01, 1);
		pushn(8'h00, 1);
		pushn(8'h40, 1);
		pushn(8'h03, 1);
		run(`EKE_OP_COPY);
		for (int k = 0; k < 3; k++) begin
			rdx("copy", 7'h40 + 7'(k), 8'hC0 + 8'(k));
		end
		flush();
		q1(8'h00);
		run(`EKE_OP_COPY);
		rdx("copy params", `EKE_IDX_ERR, 8'h01);
	endtask
	// Every receive and transmit preset number
	task automatic t_preset();
		wpage(8'h28, 8'h50, 32);
		for (int n = 0; n < 4; n++) begin
			flush();
			q1(8'(n));
			q1(8'(3 - n));
			run(`EKE_OP_PRESET);
			rdx("rx preset", `EKE_RX_CFG, 8'h50 + 8'(n));
			rdx("tx preset", `EKE_TX_CFG, 8'h63 - 8'(n));
		end
		flush();
		q1(8'h00);
		run(`EKE_OP_PRESET);
		rdx("preset params", `EKE_IDX_ERR, 8'h01);
	endtask
	// Two whole secrets and a partial one, load back, range aborts
	task automatic t_key();
		flush();
		q1(8'h01);
		pushn(8'hA0, 13);
		run(`EKE_OP_KSAVE);
		rdx("partial left", `EKE_IDX_QLEN, 8'h01);
		flush();
		q1(8'h02);
		run(`EKE_OP_KLOAD);
		chk("secret", secret_key, 48'hA6A7A8A9AAAB);
		flush();
		q1(8'h80);
		run(`EKE_OP_KLOAD);
		rdx("load range", `EKE_IDX_ERR, 8'h02);
		flush();
		q1(8'h80);
		pushn(8'hA0, 6);
		run(`EKE_OP_KSAVE);
		rdx("save range", `EKE_IDX_ERR, 8'h02);
	endtask
	// Random fill stopped by idle, then run to full; defaults reload
	task automatic t_rand_reload();
		flush();
		wr(`EKE_IDX_CMD, `EKE_OP_RAND);
		wr(`EKE_IDX_CMD, `EKE_OP_IDLE);
		rdx("stopped", `EKE_IDX_CMD, 8'h00);
		rdx("not full", `EKE_IDX_QCTL, 8'h00);
		rdx("idle status", `EKE_IDX_STAT, 8'h00);
		flush();
		run(`EKE_OP_RAND);
		rdx("full high", `EKE_IDX_QCTL, 8'h01);
		rdx("full low", `EKE_IDX_QLEN, 8'h00);
		wpage(8'h02, 8'h00, 4);
		run(`EKE_OP_RELOAD);
		rdx("reload thr", `EKE_IDX_QTHR, 8'h03);
		rdx("reload hctl", `EKE_IDX_HCTL, 8'h01);
	endtask

	////////////////////////////////////////////////////////////////////
	// Clock
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	// Watchdog against a hung handshake
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_mismatch++;
			stop_test();
		end
	end
	// Main sequence
	initial begin
		hresetn = 1'b0;
		n_mismatch = 0;
		checked = 0;
		cyc = 0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_page();
		t_fetch_copy();
		t_preset();
		t_key();
		t_rand_reload();
		stop_test();
	end
endmodule
`default_nettype wire
